// File: exec_pkg.sv
// Shared constants, operation codes and state record for the instruction execution block.
package exec_pkg;

  // ----------------------------------------------------------------
  // Widths and constants
  // ----------------------------------------------------------------
  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 7;
  localparam int          PC_W          = 15;
  localparam int          LATCH_W       = 7;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
  localparam logic [7:0]  BYTE_ONE      = 8'h01;
  localparam logic [14:0] PC_STEP       = 15'h0001;
  localparam logic [14:0] PC_ZERO       = 15'h0000;
  localparam logic [6:0]  ADDR_ZERO     = 7'h00;
  localparam logic [6:0]  FILE_ADDR_MAX = 7'h7F;
  localparam logic        DEST_WORKING  = 1'b0;
  localparam logic        DEST_FILE     = 1'b1;
  localparam logic        FLAG_SET      = 1'b1;
  localparam logic        FLAG_CLEAR    = 1'b0;

  // ----------------------------------------------------------------
  // Operation codes and machine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    no_op,
    watchdog_clear_op,
    call_via_working_op,
    complement_file_op,
    clear_file_op,
    decrement_file_op,
    clear_working_op,
    decrement_skip_zero_op
  } op_t;

  typedef enum logic [1:0] {
    alu_clear,
    alu_complement,
    alu_decrement
  } alu_fn_t;

  typedef enum logic [1:0] {
    st_idle,
    st_call_load,
    st_skip_nop
  } exec_st_t;

  typedef struct packed {
    exec_st_t    st;
    logic        push_en;
    logic [14:0] push_data;
    logic        pc_load_en;
    logic [14:0] pc_load_value;
    logic [14:0] call_target;
    logic        rf_wr_en;
    logic [6:0]  rf_wr_addr;
    logic [7:0]  rf_wr_data;
    logic        w_wr_en;
    logic [7:0]  w_wr_data;
    logic        zero_wr_en;
    logic        zero_wr_data;
    logic        wdt_clear;
    logic        timeout_flag;
    logic        powerdown_flag;
    logic        discard_next;
    logic        done;
  } exec_state_t;

  localparam exec_state_t EXEC_RESET = '{
    st: st_idle, push_en: 1'b0, push_data: PC_ZERO, pc_load_en: 1'b0,
    pc_load_value: PC_ZERO, call_target: PC_ZERO, rf_wr_en: 1'b0,
    rf_wr_addr: ADDR_ZERO, rf_wr_data: BYTE_ZERO, w_wr_en: 1'b0,
    w_wr_data: BYTE_ZERO, zero_wr_en: 1'b0, zero_wr_data: 1'b0,
    wdt_clear: 1'b0, timeout_flag: FLAG_SET, powerdown_flag: FLAG_SET,
    discard_next: 1'b0, done: 1'b0};

endpackage : exec_pkg

// File: alu_if.sv
// Carrier between the execution core and its byte arithmetic unit.
`timescale 1ns/100ps
interface alu_if;
  import exec_pkg::*;
  alu_fn_t    fn;
  logic [7:0] operand;
  logic [7:0] result;
  logic       zero;
  modport core (output fn, output operand, input result, input zero);
  modport unit (input fn, input operand, output result, output zero);
endinterface : alu_if

// File: byte_alu.sv
// Byte arithmetic for clear, complement and decrement with zero detection.
`timescale 1ns/100ps
module byte_alu (
  alu_if.unit alu
);
  import exec_pkg::*;

  always_comb begin
    case (alu.fn)
      alu_complement: alu.result = ~alu.operand;
      alu_decrement:  alu.result = alu.operand - BYTE_ONE;
      default:        alu.result = BYTE_ZERO;
    endcase
  end

  assign alu.zero = (alu.result == BYTE_ZERO);

endmodule : byte_alu

// File: clear_call_dec_exec.sv
// Execution unit for watchdog clear, call through working, complement, clear and decrement.
`timescale 1ns/100ps
module clear_call_dec_exec (
  // Clock and reset
  input  wire logic                           mclk,
  input  wire logic                           rstn,
  // Instruction request from the sequencer
  input  wire logic                           op_valid,
  input  wire exec_pkg::op_t                  op_code,
  input  wire logic [exec_pkg::ADDR_W-1:0]    op_file_addr,
  input  wire logic                           op_dest,
  output logic                                op_ready,
  output logic                                op_done,
  output logic                                discard_next,
  // Register file
  output logic [exec_pkg::ADDR_W-1:0]         rf_rd_addr,
  input  wire logic [exec_pkg::DATA_W-1:0]    rf_rd_data,
  output logic                                rf_wr_en,
  output logic [exec_pkg::ADDR_W-1:0]         rf_wr_addr,
  output logic [exec_pkg::DATA_W-1:0]         rf_wr_data,
  // Working register
  input  wire logic [exec_pkg::DATA_W-1:0]    w_in,
  output logic                                w_wr_en,
  output logic [exec_pkg::DATA_W-1:0]         w_wr_data,
  // Zero flag update
  output logic                                zero_wr_en,
  output logic                                zero_wr_data,
  // Program counter and return stack
  input  wire logic [exec_pkg::PC_W-1:0]      pc_in,
  input  wire logic [exec_pkg::LATCH_W-1:0]   pc_upper_latch,
  output logic                                pc_load_en,
  output logic [exec_pkg::PC_W-1:0]           pc_load_value,
  output logic                                push_en,
  output logic [exec_pkg::PC_W-1:0]           push_data,
  // Watchdog and power status
  input  wire logic                           timeout_event,
  input  wire logic                           powerdown_event,
  output logic                                wdt_clear,
  output logic                                timeout_flag,
  output logic                                powerdown_flag
);
  import exec_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [14:0] pc_plus_one(input logic [14:0] pc);
    pc_plus_one = pc + PC_STEP;
  endfunction : pc_plus_one

  function automatic logic routes_result(input op_t op);
    routes_result = (op == complement_file_op) || (op == decrement_file_op) ||
                    (op == decrement_skip_zero_op);
  endfunction : routes_result

  exec_state_t q;
  exec_state_t d;
  logic        accept;
  logic [14:0] call_tgt;

  alu_if alu ();

  byte_alu u_alu (
    .alu (alu)
  );

  assign op_ready   = (q.st == st_idle);
  assign accept     = op_valid && op_ready;
  assign rf_rd_addr = op_file_addr;
  assign call_tgt   = {pc_upper_latch, w_in};

  always_comb begin
    case (op_code)
      complement_file_op:     alu.fn = alu_complement;
      decrement_file_op:      alu.fn = alu_decrement;
      decrement_skip_zero_op: alu.fn = alu_decrement;
      default:                alu.fn = alu_clear;
    endcase
  end

  assign alu.operand = rf_rd_data;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d              = q;
    d.push_en      = 1'b0;
    d.pc_load_en   = 1'b0;
    d.rf_wr_en     = 1'b0;
    d.w_wr_en      = 1'b0;
    d.zero_wr_en   = 1'b0;
    d.wdt_clear    = 1'b0;
    d.discard_next = 1'b0;
    d.done         = 1'b0;
    // External events clear the status flags; an instruction set below wins.
    if (timeout_event) begin
      d.timeout_flag = FLAG_CLEAR;
    end
    if (powerdown_event) begin
      d.powerdown_flag = FLAG_CLEAR;
    end
    case (q.st)
      st_idle: begin
        if (accept) begin
          if (routes_result(op_code)) begin
            if (op_dest == DEST_FILE) begin
              d.rf_wr_en   = 1'b1;
              d.rf_wr_addr = op_file_addr;
              d.rf_wr_data = alu.result;
            end else begin
              d.w_wr_en   = 1'b1;
              d.w_wr_data = alu.result;
            end
          end
          case (op_code)
            watchdog_clear_op: begin
              d.wdt_clear      = 1'b1;
              d.timeout_flag   = FLAG_SET;
              d.powerdown_flag = FLAG_SET;
              d.done           = 1'b1;
            end
            call_via_working_op: begin
              d.push_en     = 1'b1;
              d.push_data   = pc_plus_one(pc_in);
              d.call_target = call_tgt;
              d.st          = st_call_load;
            end
            complement_file_op, decrement_file_op: begin
              d.zero_wr_en   = 1'b1;
              d.zero_wr_data = alu.zero;
              d.done         = 1'b1;
            end
            clear_file_op: begin
              d.rf_wr_en     = 1'b1;
              d.rf_wr_addr   = op_file_addr;
              d.rf_wr_data   = BYTE_ZERO;
              d.zero_wr_en   = 1'b1;
              d.zero_wr_data = FLAG_SET;
              d.done         = 1'b1;
            end
            clear_working_op: begin
              d.w_wr_en      = 1'b1;
              d.w_wr_data    = BYTE_ZERO;
              d.zero_wr_en   = 1'b1;
              d.zero_wr_data = FLAG_SET;
              d.done         = 1'b1;
            end
            decrement_skip_zero_op: begin
              if (alu.zero) begin
                d.discard_next = 1'b1;
                d.st           = st_skip_nop;
              end else begin
                d.done = 1'b1;
              end
            end
            default: begin
              d.done = 1'b1;
            end
          endcase
        end
      end
      st_call_load: begin
        d.pc_load_en    = 1'b1;
        d.pc_load_value = q.call_target;
        d.done          = 1'b1;
        d.st            = st_idle;
      end
      st_skip_nop: begin
        d.done = 1'b1;
        d.st   = st_idle;
      end
      default: begin
        d.st = st_idle;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= EXEC_RESET;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign op_done        = q.done;
  assign discard_next   = q.discard_next;
  assign rf_wr_en       = q.rf_wr_en;
  assign rf_wr_addr     = q.rf_wr_addr;
  assign rf_wr_data     = q.rf_wr_data;
  assign w_wr_en        = q.w_wr_en;
  assign w_wr_data      = q.w_wr_data;
  assign zero_wr_en     = q.zero_wr_en;
  assign zero_wr_data   = q.zero_wr_data;
  assign pc_load_en     = q.pc_load_en;
  assign pc_load_value  = q.pc_load_value;
  assign push_en        = q.push_en;
  assign push_data      = q.push_data;
  assign wdt_clear      = q.wdt_clear;
  assign timeout_flag   = q.timeout_flag;
  assign powerdown_flag = q.powerdown_flag;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [7:0] exp_comp;
  logic [7:0] exp_dec;
  assign exp_comp = ~rf_rd_data;
  assign exp_dec  = rf_rd_data - BYTE_ONE;

  property p_wdt_clear;
    @(posedge mclk) disable iff (!rstn)
      accept && op_code == watchdog_clear_op |=> wdt_clear && op_done;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog clear not issued");

  property p_flags_set;
    @(posedge mclk) disable iff (!rstn)
      accept && op_code == watchdog_clear_op |=> timeout_flag && powerdown_flag && !zero_wr_en;
  endproperty
  a_flags_set: assert property (p_flags_set) else $error("status flags not set");

  property p_call_push;
    @(posedge mclk) disable iff (!rstn)
      accept && op_code == call_via_working_op |=> push_en && push_data == $past(pc_in) + PC_STEP;
  endproperty
  a_call_push: assert property (p_call_push) else $error("wrong return address pushed");

  property p_call_load;
    @(posedge mclk) disable iff (!rstn)
      accept && op_code == call_via_working_op |-> ##1 !pc_load_en ##1 pc_load_en &&
      pc_load_value == $past(call_tgt, 2);
  endproperty
  a_call_load: assert property (p_call_load) else $error("call target wrong");

  property p_call_two;
    @(posedge mclk) disable iff (!rstn)
      accept && op_code == call_via_working_op |=> (!op_ready && !op_done && !zero_wr_en) ##1
      (op_done && !zero_wr_en && $stable(timeout_flag));
  endproperty
  a_call_two: assert property (p_call_two) else $error("call timing or flags wrong");

  property p_comp;
    @(posedge mclk) disable iff (!rstn)
      accept && op_code == complement_file_op |=> zero_wr_en &&
      (($past(op_dest) == DEST_FILE) ? (rf_wr_en && rf_wr_data == $past(exp_comp) && !w_wr_en)
                                     : (w_wr_en && w_wr_data == $past(exp_comp) && !rf_wr_en));
  endproperty
  a_comp: assert property (p_comp) else $error("complement result wrong");

  property p_clear_file_op;
    @(posedge mclk) disable iff (!rstn)
      accept && op_code == clear_file_op |=> rf_wr_en && rf_wr_data == BYTE_ZERO &&
      rf_wr_addr == $past(op_file_addr) && zero_wr_en && zero_wr_data;
  endproperty
  a_clear_file_op: assert property (p_clear_file_op) else $error("clear file wrong");

  property p_clear_working_op;
    @(posedge mclk) disable iff (!rstn)
      accept && op_code == clear_working_op |=> w_wr_en && w_wr_data == BYTE_ZERO &&
      !rf_wr_en && zero_wr_en && zero_wr_data;
  endproperty
  a_clear_working_op: assert property (p_clear_working_op) else $error("clear working wrong");

  property p_dec;
    @(posedge mclk) disable iff (!rstn)
      accept && op_code == decrement_file_op |=> zero_wr_en &&
      (($past(op_dest) == DEST_FILE) ? (rf_wr_en && rf_wr_data == $past(exp_dec))
                                     : (w_wr_en && w_wr_data == $past(exp_dec)));
  endproperty
  a_dec: assert property (p_dec) else $error("decrement result wrong");

  property p_dskip;
    @(posedge mclk) disable iff (!rstn)
      accept && op_code == decrement_skip_zero_op |=> !zero_wr_en &&
      (($past(op_dest) == DEST_FILE) ? (rf_wr_en && rf_wr_data == $past(exp_dec))
                                     : (w_wr_en && w_wr_data == $past(exp_dec)));
  endproperty
  a_dskip: assert property (p_dskip) else $error("decrement skip wrong");

  property p_skip;
    @(posedge mclk) disable iff (!rstn)
      accept && op_code == decrement_skip_zero_op && rf_rd_data == BYTE_ONE |=>
      discard_next && !op_done ##1 op_done && !discard_next;
  endproperty
  a_skip: assert property (p_skip) else $error("skip not taken");

  property p_noskip;
    @(posedge mclk) disable iff (!rstn)
      accept && op_code == decrement_skip_zero_op && rf_rd_data != BYTE_ONE |=>
      op_done && !discard_next && op_ready;
  endproperty
  a_noskip: assert property (p_noskip) else $error("unexpected skip");

  property p_zero;
    @(posedge mclk) disable iff (!rstn)
      zero_wr_en |-> zero_wr_data == (rf_wr_en ? (rf_wr_data == BYTE_ZERO) : (w_wr_data == BYTE_ZERO));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag mismatch");

  property p_single;
    @(posedge mclk) disable iff (!rstn)
      accept && (op_code == complement_file_op || op_code == decrement_file_op ||
      op_code == clear_file_op || op_code == clear_working_op) |=> op_done && op_ready;
  endproperty
  a_single: assert property (p_single) else $error("single cycle op took longer");

  c_call: cover property (@(posedge mclk) disable iff (!rstn)
    accept && op_code == call_via_working_op ##2 op_done);
  c_skip: cover property (@(posedge mclk) disable iff (!rstn) discard_next ##1 op_done);
  c_wdt: cover property (@(posedge mclk) disable iff (!rstn) timeout_event ##1 wdt_clear);
  c_dec_zero: cover property (@(posedge mclk) disable iff (!rstn) zero_wr_en && zero_wr_data);

endmodule : clear_call_dec_exec

// File: exec_partner.sv
// Behavioural register file, working register, zero flag, program counter and return stack.
`timescale 1ns/100ps
module exec_partner (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Register file
  input  wire logic [6:0]  rf_rd_addr,
  output logic [7:0]       rf_rd_data,
  input  wire logic        rf_wr_en,
  input  wire logic [6:0]  rf_wr_addr,
  input  wire logic [7:0]  rf_wr_data,
  // Working register and zero flag
  output logic [7:0]       w_in,
  input  wire logic        w_wr_en,
  input  wire logic [7:0]  w_wr_data,
  input  wire logic        zero_wr_en,
  input  wire logic        zero_wr_data,
  // Program counter and return stack
  output logic [14:0]      pc_in,
  input  wire logic        pc_load_en,
  input  wire logic [14:0] pc_load_value,
  input  wire logic        push_en,
  input  wire logic [14:0] push_data,
  // Preload and observation by the bench
  input  wire logic        set_en,
  input  wire logic [6:0]  set_addr,
  input  wire logic [7:0]  set_data,
  input  wire logic [7:0]  set_w,
  input  wire logic        set_z,
  input  wire logic [14:0] set_pc,
  input  wire logic [6:0]  peek_addr,
  output logic [7:0]       peek_data,
  output logic             zero_q,
  output logic [14:0]      tos_q
);
  logic [7:0]  mem_q [0:127];
  logic [14:0] pc_q;
  logic [7:0]  w_q;

  assign rf_rd_data = mem_q[rf_rd_addr];
  assign peek_data  = mem_q[peek_addr];
  assign w_in       = w_q;
  assign pc_in      = pc_q;

  always @(posedge mclk) begin
    if (set_en) begin
      mem_q[set_addr] <= set_data;
    end else if (rf_wr_en) begin
      mem_q[rf_wr_addr] <= rf_wr_data;
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      w_q    <= 8'h00;
      zero_q <= 1'b0;
      pc_q   <= 15'h0000;
      tos_q  <= 15'h0000;
    end else if (set_en) begin
      w_q    <= set_w;
      zero_q <= set_z;
      pc_q   <= set_pc;
    end else begin
      if (w_wr_en) w_q <= w_wr_data;
      if (zero_wr_en) zero_q <= zero_wr_data;
      if (pc_load_en) pc_q <= pc_load_value;
      if (push_en) tos_q <= push_data;
    end
  end
endmodule : exec_partner

// File: tb.sv
// Self-checking bench for the instruction execution block.
`timescale 1ns/100ps
module tb;
  import exec_pkg::*;
  logic mclk = 1'b0, rstn = 1'b0, op_valid = 1'b0, op_dest = 1'b0;
  op_t op_code = no_op;
  logic [6:0] op_file_addr = 7'h00, pc_upper_latch = 7'h00, set_addr = 7'h00, peek_addr = 7'h00;
  logic timeout_event = 1'b0, powerdown_event = 1'b0, set_en = 1'b0, set_z = 1'b0;
  logic [7:0] set_data = 8'h00, set_w = 8'h00;
  logic [14:0] set_pc = 15'h0000;
  logic op_ready, op_done, discard_next, rf_wr_en, w_wr_en, zero_wr_en, zero_wr_data;
  logic pc_load_en, push_en, wdt_clear, timeout_flag, powerdown_flag, zero_q;
  logic [6:0] rf_rd_addr, rf_wr_addr;
  logic [7:0] rf_rd_data, rf_wr_data, w_in, w_wr_data, peek_data;
  logic [14:0] pc_in, pc_load_value, push_data, tos_q;
  int bad_count = 0, cmp_count = 0, cyc;
  logic seen_disc, seen_wdt, seen_busy;

  always #50 mclk = ~mclk;

  clear_call_dec_exec i_clear_call_dec_exec (.mclk, .rstn, .op_valid, .op_code, .op_file_addr, .op_dest,
    .op_ready, .op_done, .discard_next, .rf_rd_addr, .rf_rd_data, .rf_wr_en, .rf_wr_addr, .rf_wr_data,
    .w_in, .w_wr_en, .w_wr_data, .zero_wr_en, .zero_wr_data, .pc_in, .pc_upper_latch, .pc_load_en,
    .pc_load_value, .push_en, .push_data, .timeout_event, .powerdown_event, .wdt_clear, .timeout_flag,
    .powerdown_flag);

  exec_partner i_exec_partner (.mclk, .rstn, .rf_rd_addr, .rf_rd_data, .rf_wr_en, .rf_wr_addr, .rf_wr_data,
    .w_in, .w_wr_en, .w_wr_data, .zero_wr_en, .zero_wr_data, .pc_in, .pc_load_en, .pc_load_value, .push_en,
    .push_data, .set_en, .set_addr, .set_data, .set_w, .set_z, .set_pc, .peek_addr, .peek_data, .zero_q,
    .tos_q);

  // ----------------------------------------------------------------
  // Access and comparison tasks
  // ----------------------------------------------------------------
  task automatic chk_v(input string name, input logic [14:0] exp, input logic [14:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_v

  task automatic chk_b(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_b

  task automatic end_sim;
    $display("Compared %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  // Preloads one file register, working, zero flag and program counter in one cycle.
  task automatic set_state(input logic [6:0] a, input logic [7:0] f, input logic [7:0] w, input logic z,
                           input logic [14:0] pc);
    @(posedge mclk);
    #1;
    set_en = 1'b1;
    set_addr = a;
    peek_addr = a;
    set_data = f;
    set_w = w;
    set_z = z;
    set_pc = pc;
    @(posedge mclk);
    #1;
    set_en = 1'b0;
  endtask : set_state

  // Issues one request, holds it until taken and counts cycles until done.
  task automatic run_op(input op_t code, input logic [6:0] a, input logic d);
    int n;
    @(posedge mclk);
    #1;
    op_valid = 1'b1;
    op_code = code;
    op_file_addr = a;
    op_dest = d;
    n = 0;
    while (op_ready !== 1'b1 && n < 8) begin
      @(posedge mclk);
      #1;
      n++;
    end
    @(posedge mclk);
    #1;
    op_valid = 1'b0;
    {seen_disc, seen_wdt, seen_busy} = 3'b000;
    cyc = 0;
    // The first result cycle is already standing here, so it is sampled before any further edge.
    do begin
      if (cyc > 0) begin
        @(posedge mclk);
        #1;
      end
      cyc++;
      if (discard_next === 1'b1) seen_disc = 1'b1;
      if (wdt_clear === 1'b1) seen_wdt = 1'b1;
      if (op_ready === 1'b0) seen_busy = 1'b1;
    end while (op_done !== 1'b1 && cyc < 8);
    @(posedge mclk);
    #1;
  endtask : run_op

  // Runs a file or working operation and checks both destinations, zero flag and timing.
  task automatic arith(input op_t code, input logic [6:0] a, input logic d, input logic [7:0] f,
                       input logic [7:0] res, input logic z_pre, input logic z_exp, input int n);
    set_state(a, f, 8'h3C, z_pre, 15'h0100);
    run_op(code, a, d);
    chk_v("file", d ? res : f, peek_data);
    chk_v("working", d ? 8'h3C : res, w_in);
    chk_b("zero", z_exp, zero_q);
    chk_v("cycles", 15'(n), 15'(cyc));
    chk_b("discard", n == 2, seen_disc);
  endtask : arith

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    #1;
    rstn = 1'b1;
    chk_b("timeout_flag", 1'b1, timeout_flag);
    chk_b("powerdown_flag", 1'b1, powerdown_flag);
    timeout_event = 1'b1;
    powerdown_event = 1'b1;
    @(posedge mclk);
    #1;
    timeout_event = 1'b0;
    powerdown_event = 1'b0;
    chk_b("timeout_flag", 1'b0, timeout_flag);
    chk_b("powerdown_flag", 1'b0, powerdown_flag);
    set_state(7'h05, 8'h11, 8'h22, 1'b0, 15'h0040);
    run_op(watchdog_clear_op, 7'h05, 1'b0);
    chk_b("wdt_clear", 1'b1, seen_wdt);
    chk_b("timeout_flag", 1'b1, timeout_flag);
    chk_b("powerdown_flag", 1'b1, powerdown_flag);
    chk_b("zero", 1'b0, zero_q);
    set_state(7'h10, 8'h00, 8'hA5, 1'b1, 15'h1234);
    pc_upper_latch = 7'h5B;
    run_op(call_via_working_op, 7'h10, 1'b0);
    chk_v("stack_top", 15'h1235, tos_q);
    chk_v("pc", 15'h5BA5, pc_in);
    chk_v("cycles", 15'h0002, 15'(cyc));
    chk_b("busy", 1'b1, seen_busy);
    chk_b("zero", 1'b1, zero_q);
    arith(no_op, 7'h01, 1'b0, 8'h77, 8'h3C, 1'b1, 1'b1, 1);
    arith(complement_file_op, 7'h00, 1'b0, 8'hFF, 8'h00, 1'b0, 1'b1, 1);
    arith(complement_file_op, 7'h7F, 1'b1, 8'h5A, 8'hA5, 1'b1, 1'b0, 1);
    arith(clear_file_op, 7'h7F, 1'b1, 8'h33, 8'h00, 1'b0, 1'b1, 1);
    arith(clear_working_op, 7'h12, 1'b0, 8'h44, 8'h00, 1'b0, 1'b1, 1);
    arith(decrement_file_op, 7'h20, 1'b1, 8'h01, 8'h00, 1'b0, 1'b1, 1);
    arith(decrement_file_op, 7'h21, 1'b0, 8'h00, 8'hFF, 1'b1, 1'b0, 1);
    arith(decrement_skip_zero_op, 7'h30, 1'b1, 8'h01, 8'h00, 1'b0, 1'b0, 2);
    arith(decrement_skip_zero_op, 7'h31, 1'b0, 8'h01, 8'h00, 1'b1, 1'b1, 2);
    arith(decrement_skip_zero_op, 7'h32, 1'b0, 8'h00, 8'hFF, 1'b1, 1'b1, 1);
    end_sim();
  end

  initial begin
    #(3000 * 100);
    bad_count++;
    end_sim();
  end
endmodule : tb
